// ==== hw/rfpm_top.sv ====
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rfpm_defines.svh"
module rfpm_top import rfpm_pkg::*; #(
    parameter int BIDIR_CYCLES = (`RFPM_BIDIR_TCL * `RFPM_HALF_CLK_NS) / `RFPM_CLK_NS,
    parameter int LONG_CYCLES = 1032
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Reset pins and straps
    input wire logic RESET_INPUT_PIN_B,
    output logic RESET_PIN_O,
    output logic RESET_PIN_OE_B,
    input wire logic RESET_DELAY_PIN,
    input wire logic EXTERNAL_ACCESS_PIN,
    input wire logic BIDIR_EN,
    input wire logic [15:0] PORT0_PINS,
    // Power mode inputs
    input wire logic NMI_PIN_B,
    input wire logic [7:0] FAST_EXT_IRQ_PIN,
    input wire logic [7:0] FAST_IRQ_ENABLE,
    input wire logic [7:0] FAST_IRQ_ACTIVE_HIGH,
    input wire logic IRQ_REQ,
    input wire logic RTC_IRQ,
    input wire logic CAN_I2C_IRQ,
    input wire logic BUS_BUSY,
    input wire logic READY_SEEN,
    input wire logic LP_OSC_RUNNING,
    // Mode outputs
    output logic CPU_STOP,
    output logic PERIPH_STOP,
    output logic WDOG_HOLD,
    output logic MAIN_OSC_RUN,
    output logic RTC_USE_LP_OSC,
    output logic ENTRY_REFUSED,
    output logic [15:0] RESET_CONFIG_LATCH
);
    initial begin
        if (BIDIR_CYCLES < 1 || BIDIR_CYCLES > 65535 || LONG_CYCLES < 1 || LONG_CYCLES > 65535) begin
            $error("rfpm_top: cycle counts out of range");
        end
    end

    // Two-flop synchronisers for pins
    logic [14:0] s1_q, s2_q;
    logic [15:0] p0_s1_q, p0_q;
    always_ff @(posedge CLK) begin
        s1_q <= {RESET_INPUT_PIN_B, RESET_DELAY_PIN, EXTERNAL_ACCESS_PIN, NMI_PIN_B, BIDIR_EN,
                 IRQ_REQ, RTC_IRQ, CAN_I2C_IRQ, LP_OSC_RUNNING, 6'h00};
        s2_q <= s1_q;
        p0_s1_q <= PORT0_PINS;
        p0_q <= p0_s1_q;
    end
    logic [7:0] fx_s1_q, fx_q;
    always_ff @(posedge CLK) begin
        fx_s1_q <= FAST_EXT_IRQ_PIN;
        fx_q <= fx_s1_q;
    end
    logic rst_in_b, reset_delay_pin, ea, nmi_b, bidir, irq, rtc_irq, cani_irq, lp_run;
    assign rst_in_b = s2_q[14];
    assign reset_delay_pin = s2_q[13];
    assign ea = s2_q[12];
    assign nmi_b = s2_q[11];
    assign bidir = s2_q[10];
    assign irq = s2_q[9];
    assign rtc_irq = s2_q[8];
    assign cani_irq = s2_q[7];
    assign lp_run = s2_q[6];

    // Active fast pins, level polarity per pin
    logic [7:0] fast_act;
    assign fast_act = FAST_IRQ_ENABLE & ~(fx_q ^ FAST_IRQ_ACTIVE_HIGH);

    // Registers
    logic [31:0] ctrl_q;
    logic [4:0] flags_q;
    logic pon_seen_q;
    logic lp_sel_q;
    rfpm_mode_t mode_q;
    logic prot_q;
    logic refused_q;
    logic [15:0] cfg_q;
    logic [15:0] drive_cnt_q;
    logic [15:0] hw_cnt_q;
    logic hw_active_q;
    logic soft_pend_q;
    logic [1:0] own_tail_q;
    logic own_drive;
    // Own pulse plus synchroniser lag, so our drive never reads as an external reset to the flags; the mode state machine still sees it
    assign own_drive = (drive_cnt_q != 16'h0000) || (own_tail_q != 2'b00);

    // AHB address phase capture
    rfpm_ahb_req_t req_q;
    logic wr_pend_q, rd_pend_q;
    logic take;
    assign take = HSEL && HTRANS[1];
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            req_q <= '0;
        end else begin
            wr_pend_q <= take && HWRITE;
            rd_pend_q <= take && !HWRITE;
            if (take) begin
                req_q <= '{htrans: HTRANS, hwrite: HWRITE, hsize: HSIZE, haddr: HADDR};
            end
        end
    end
    // Zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // Command strobes from writes to the command word
    logic cmd_wr, cmd_idle, cmd_pdn, cmd_sw, cmd_wd;
    assign cmd_wr = wr_pend_q && (req_q.haddr == `RFPM_OFS_CMD);
    assign cmd_idle = cmd_wr && HWDATA[`RFPM_CMD_IDLE_BIT];
    assign cmd_pdn = cmd_wr && HWDATA[`RFPM_CMD_POWER_DOWN_INSTRUCTION_BIT];
    assign cmd_sw = cmd_wr && HWDATA[`RFPM_CMD_SWRST_BIT];
    assign cmd_wd = cmd_wr && HWDATA[`RFPM_CMD_WDRST_BIT];

    // Read mux registered so data comes from flops
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            HRDATA <= 32'h0000_0000;
        end else if (take && !HWRITE) begin
            case (HADDR)
                `RFPM_OFS_CTRL: HRDATA <= ctrl_q;
                `RFPM_OFS_STAT: HRDATA <= {23'h00_0000, refused_q, mode_q, flags_q};
                `RFPM_OFS_CFG: HRDATA <= {16'h0000, cfg_q};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Control register; regulator-off is software's duty before power-down
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ctrl_q <= `RFPM_CTRL_RST;
        end else if (wr_pend_q && req_q.haddr == `RFPM_OFS_CTRL) begin
            ctrl_q <= HWDATA;
        end
    end

    // External reset: short until LONG_CYCLES, then long; async at any length while RESET_DELAY_PIN is low
    logic ext_rst;
    assign ext_rst = !rst_in_b;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            hw_cnt_q <= 16'h0000;
            hw_active_q <= 1'b0;
        end else if (ext_rst && !own_drive) begin
            hw_active_q <= 1'b1;
            if (hw_cnt_q != 16'hFFFF) begin
                hw_cnt_q <= hw_cnt_q + 16'h0001;
            end
        end else begin
            hw_active_q <= 1'b0;
            hw_cnt_q <= 16'h0000;
        end
    end
    logic hw_end, hw_long, hw_async;
    assign hw_end = hw_active_q && !(ext_rst && !own_drive);
    assign hw_long = hw_cnt_q >= 16'(LONG_CYCLES);
    assign hw_async = !reset_delay_pin;

    // Bidirectional drive of the reset pin
    logic drive_req;
    assign drive_req = (cmd_sw || cmd_wd) && bidir && reset_delay_pin && ea;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            drive_cnt_q <= 16'h0000;
        end else if (drive_req) begin
            drive_cnt_q <= 16'(BIDIR_CYCLES);
        end else if (drive_cnt_q != 16'h0000) begin
            drive_cnt_q <= drive_cnt_q - 16'h0001;
        end
    end
    // Two-cycle tail matches the pin synchroniser depth
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            own_tail_q <= 2'b00;
        end else begin
            own_tail_q <= {own_tail_q[0], drive_cnt_q != 16'h0000};
        end
    end
    assign RESET_PIN_O = 1'b0;
    assign RESET_PIN_OE_B = (drive_cnt_q == 16'h0000);

    // Sampling mask per reset kind
    function automatic logic [15:0] kind_mask(input rfpm_rst_kind_t k);
        case (k)
            RFPM_R_SOFT, RFPM_R_WDOG: kind_mask = `RFPM_MASK_SOFT;
            RFPM_R_SHORT: kind_mask = `RFPM_MASK_SHORT;
            default: kind_mask = `RFPM_MASK_ALL;
        endcase
    endfunction
    function automatic logic [15:0] merge(input logic [15:0] old, input rfpm_rst_kind_t k, input logic [15:0] p);
        logic [15:0] m;
        m = kind_mask(k);
        merge = (old & ~m) | (p & m);
    endfunction

    // Reset-source flags and configuration latch
    rfpm_rst_kind_t hw_kind;
    assign hw_kind = hw_async ? RFPM_R_ASYNC : (hw_long ? RFPM_R_LONG : RFPM_R_SHORT);
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            flags_q <= 5'h1F;
            cfg_q <= 16'h0000;
            pon_seen_q <= 1'b0;
        end else if (!pon_seen_q) begin
            pon_seen_q <= 1'b1;
            cfg_q <= merge(cfg_q, RFPM_R_PON, p0_q);
        end else if (hw_end) begin
            // A later hardware reset overrides soft flags
            flags_q <= (hw_async || hw_long) ? 5'h0F : 5'h05;
            cfg_q <= merge(cfg_q, hw_kind, p0_q);
        end else if (cmd_wd) begin
            flags_q <= 5'h03;
            cfg_q <= merge(cfg_q, RFPM_R_WDOG, p0_q);
        end else if (cmd_sw) begin
            flags_q <= 5'h01;
            cfg_q <= merge(cfg_q, RFPM_R_SOFT, p0_q);
        end
    end
    assign RESET_CONFIG_LATCH = cfg_q;
    logic unused_soft;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            soft_pend_q <= 1'b0;
        end else begin
            soft_pend_q <= cmd_sw || cmd_wd;
        end
    end
    assign unused_soft = soft_pend_q;

    // Low-power oscillator adoption
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            lp_sel_q <= 1'b0;
        end else if (ctrl_q[`RFPM_CTRL_LPDIS_BIT]) begin
            lp_sel_q <= 1'b0;
        end else if (lp_run) begin
            lp_sel_q <= 1'b1;
        end
    end

    // Entry guards
    logic bus_ok, pdn_ok, go_idle, go_pdn, refuse;
    assign bus_ok = !BUS_BUSY && (!ctrl_q[`RFPM_CTRL_RDYEN_BIT] || READY_SEEN);
    assign pdn_ok = ctrl_q[`RFPM_CTRL_POWER_DOWN_CONFIG_BIT_BIT] ? (fast_act == 8'h00) : !nmi_b;
    assign go_idle = cmd_idle && bus_ok;
    assign go_pdn = cmd_pdn && bus_ok && pdn_ok;
    assign refuse = (cmd_idle || cmd_pdn) && !(go_idle || go_pdn);

    // Mode state machine; RST_B or the external reset pin returns to run
    always_ff @(posedge CLK) begin
        if (!RST_B || ext_rst) begin
            mode_q <= RFPM_RUN;
            prot_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (cmd_idle || cmd_pdn) begin
                refused_q <= refuse;
            end
            case (mode_q)
                RFPM_RUN: begin
                    if (cmd_sw || cmd_wd) begin
                        mode_q <= RFPM_RUN;
                    end else if (go_pdn) begin
                        mode_q <= RFPM_PDN;
                        prot_q <= !ctrl_q[`RFPM_CTRL_POWER_DOWN_CONFIG_BIT_BIT];
                    end else if (go_idle) begin
                        mode_q <= RFPM_IDLE;
                    end
                end
                RFPM_IDLE: begin
                    if (irq) begin
                        mode_q <= RFPM_RUN;
                    end
                end
                RFPM_PDN: begin
                    if (!prot_q && ((fast_act != 8'h00) || rtc_irq || cani_irq)) begin
                        mode_q <= RFPM_RUN;
                    end
                end
                default: mode_q <= RFPM_RUN;
            endcase
        end
    end

    // Mode outputs
    logic pdn;
    assign pdn = (mode_q == RFPM_PDN);
    assign CPU_STOP = (mode_q != RFPM_RUN);
    assign PERIPH_STOP = pdn;
    assign WDOG_HOLD = pdn;
    assign RTC_USE_LP_OSC = lp_sel_q;
    // Main osc stays on in power-down only when RTC counts from it
    assign MAIN_OSC_RUN = !pdn || (ctrl_q[`RFPM_CTRL_RTCEN_BIT] && !lp_sel_q);
    assign ENTRY_REFUSED = refused_q;
endmodule : rfpm_top
`default_nettype wire

// ==== hw/rfpm_defines.svh ====
`ifndef RFPM_DEFINES_SVH
`define RFPM_DEFINES_SVH
// Half clock period in ns at 50 MHz core clock
`define RFPM_HALF_CLK_NS 10
`define RFPM_CLK_NS 20
// Bidirectional reset pulse length in half clock periods
`define RFPM_BIDIR_TCL 1024
// Fast interrupt minimum wake pulse in ns
`define RFPM_FAST_IRQ_NS 40
// Register byte offsets
`define RFPM_OFS_CTRL 12'h000
`define RFPM_OFS_STAT 12'h004
`define RFPM_OFS_CFG 12'h008
`define RFPM_OFS_CMD 12'h00C
// Control field positions
`define RFPM_CTRL_POWER_DOWN_CONFIG_BIT_BIT 5
`define RFPM_CTRL_REGOFF_BIT 0
`define RFPM_CTRL_RTCEN_BIT 1
`define RFPM_CTRL_LPDIS_BIT 2
`define RFPM_CTRL_RDYEN_BIT 3
// Command bits
`define RFPM_CMD_IDLE_BIT 0
`define RFPM_CMD_POWER_DOWN_INSTRUCTION_BIT 1
`define RFPM_CMD_SWRST_BIT 2
`define RFPM_CMD_WDRST_BIT 3
// Status flag positions
`define RFPM_ST_SWR 0
`define RFPM_ST_WDT 1
`define RFPM_ST_SHW 2
`define RFPM_ST_LHW 3
`define RFPM_ST_PON 4
// Port-0 sampling masks
`define RFPM_MASK_SOFT 16'h1FC0
`define RFPM_MASK_SHORT 16'h1FFF
`define RFPM_MASK_ALL 16'hFFFF
`define RFPM_CTRL_RST 32'h0000_0000
`endif

// ==== hw/rfpm_pkg.sv ====
package rfpm_pkg;
    typedef enum logic [2:0] {
        RFPM_RUN = 3'b001,
        RFPM_IDLE = 3'b010,
        RFPM_PDN = 3'b100
    } rfpm_mode_t;
    typedef enum logic [2:0] {
        RFPM_R_PON = 3'd0,
        RFPM_R_ASYNC = 3'd1,
        RFPM_R_SHORT = 3'd2,
        RFPM_R_LONG = 3'd3,
        RFPM_R_SOFT = 3'd4,
        RFPM_R_WDOG = 3'd5
    } rfpm_rst_kind_t;
    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [11:0] haddr;
    } rfpm_ahb_req_t;
endpackage : rfpm_pkg

// ==== dv/rfpm_ext_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rfpm_ext_model (
    // Clock
    input wire logic clk,
    // Device side of the reset pin
    input wire logic pin_o,
    input wire logic pin_oe_b,
    // Wire levels seen by the device
    output logic reset_b,
    output logic [7:0] fast_pins
);
    logic ext_b = 1'b1;
    // Pulled-up line: low if either party pulls it low
    assign reset_b = ext_b & (pin_oe_b | pin_o);
    initial fast_pins = 8'h00;
    // Hold for n cycles, short or long, before release
    task automatic hold_reset(input int n);
        @(posedge clk);
        ext_b <= 1'b0;
        repeat (n) @(posedge clk);
        ext_b <= 1'b1;
    endtask : hold_reset
    // Three cycles clears the 40 ns floor with margin
    task automatic pulse(input int idx, input int n);
        @(posedge clk);
        fast_pins[idx] <= 1'b1;
        repeat (n) @(posedge clk);
        fast_pins[idx] <= 1'b0;
    endtask : pulse
endmodule : rfpm_ext_model
`default_nettype wire

// ==== dv/rfpm_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module rfpm_checker import rfpm_pkg::*; #(
    parameter int BIDIR_CYCLES = 512,
    parameter int LONG_CYCLES = 1032
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Watched ports
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic RESET_INPUT_PIN_B,
    input wire logic RESET_PIN_O,
    input wire logic RESET_PIN_OE_B,
    input wire logic BUS_BUSY,
    input wire logic IRQ_REQ,
    input wire logic CPU_STOP,
    input wire logic PERIPH_STOP,
    input wire logic WDOG_HOLD,
    input wire logic MAIN_OSC_RUN,
    input wire logic RTC_USE_LP_OSC
);
    int oe_cnt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Length of the device-driven pulse, restarted by reset
    always_ff @(posedge CLK) begin
        if (!RST_B || RESET_PIN_OE_B) begin
            oe_cnt <= 0;
        end else begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    pulse_length_a: assert property ($rose(RESET_PIN_OE_B) |-> oe_cnt == BIDIR_CYCLES)
        else $error("reset pulse length wrong");
    pulse_bound_a: assert property (oe_cnt <= BIDIR_CYCLES)
        else $error("reset pulse too long");
    pin_low_a: assert property (!RESET_PIN_OE_B |-> !RESET_PIN_O)
        else $error("reset pin driven high");
    idle_exit_a: assert property (CPU_STOP && !PERIPH_STOP && IRQ_REQ |-> ##[1:4] !CPU_STOP)
        else $error("idle not left on interrupt");
    busy_refuse_a: assert property (!CPU_STOP && BUS_BUSY && $past(BUS_BUSY) |=> !CPU_STOP)
        else $error("stopped with bus busy");
    pdn_hold_a: assert property (PERIPH_STOP |-> CPU_STOP && WDOG_HOLD)
        else $error("power-down leaves parts running");
    run_clocks_a: assert property (!PERIPH_STOP |-> !WDOG_HOLD && MAIN_OSC_RUN)
        else $error("peripherals held outside power-down");
    lp_osc_a: assert property (PERIPH_STOP && RTC_USE_LP_OSC |-> !MAIN_OSC_RUN)
        else $error("main oscillator runs beside low-power one");
    ext_run_a: assert property (!RESET_INPUT_PIN_B [*4] |-> !CPU_STOP && !PERIPH_STOP)
        else $error("external reset not back to run");
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus wait or error response");
    // Main scenarios reached
    cover property ($fell(RESET_PIN_OE_B));
    cover property ($rose(CPU_STOP) && !PERIPH_STOP);
    cover property ($rose(PERIPH_STOP));
endmodule : rfpm_checker
bind rfpm_top rfpm_checker #(.BIDIR_CYCLES(BIDIR_CYCLES), .LONG_CYCLES(LONG_CYCLES)) chk (
    .CLK(CLK), .RST_B(RST_B), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .RESET_INPUT_PIN_B(RESET_INPUT_PIN_B), .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE_B(RESET_PIN_OE_B),
    .BUS_BUSY(BUS_BUSY), .IRQ_REQ(IRQ_REQ), .CPU_STOP(CPU_STOP), .PERIPH_STOP(PERIPH_STOP),
    .WDOG_HOLD(WDOG_HOLD), .MAIN_OSC_RUN(MAIN_OSC_RUN), .RTC_USE_LP_OSC(RTC_USE_LP_OSC));
`default_nettype wire

// ==== dv/rfpm_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module rfpm_tb_top import rfpm_pkg::*; ;
    typedef struct packed {
        logic c; logic [5:0] n; logic d; logic [3:0] cmd; logic [15:0] p; logic [4:0] f; logic [15:0] m;
    } rfpm_row_t;
    rfpm_row_t rows [6];
    rfpm_ahb_req_t req;
    logic clk, rst_b, hsel, bidir, reset_delay_pin, ea, nmi_b, irq, rtc, can, busy, rdy, lp;
    logic hready, hresp, pin_o, pin_oe_b, rst_in_b, cpu_stop, per_stop, wd_hold, osc_run, use_lp, refused;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] p0, cfg, cfg_exp;
    logic [7:0] fast, fen, fhi;
    int miscompares, checks;
    // Short counts keep the run brief
    rfpm_top #(.BIDIR_CYCLES(8), .LONG_CYCLES(20)) uut (
        .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(req.haddr), .HTRANS(req.htrans), .HWRITE(req.hwrite),
        .HSIZE(req.hsize), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .RESET_INPUT_PIN_B(rst_in_b), .RESET_PIN_O(pin_o), .RESET_PIN_OE_B(pin_oe_b), .RESET_DELAY_PIN(reset_delay_pin),
        .EXTERNAL_ACCESS_PIN(ea), .BIDIR_EN(bidir), .PORT0_PINS(p0), .NMI_PIN_B(nmi_b), .FAST_EXT_IRQ_PIN(fast),
        .FAST_IRQ_ENABLE(fen), .FAST_IRQ_ACTIVE_HIGH(fhi), .IRQ_REQ(irq), .RTC_IRQ(rtc), .CAN_I2C_IRQ(can),
        .BUS_BUSY(busy), .READY_SEEN(rdy), .LP_OSC_RUNNING(lp), .CPU_STOP(cpu_stop), .PERIPH_STOP(per_stop),
        .WDOG_HOLD(wd_hold), .MAIN_OSC_RUN(osc_run), .RTC_USE_LP_OSC(use_lp), .ENTRY_REFUSED(refused),
        .RESET_CONFIG_LATCH(cfg));
    rfpm_ext_model ext (.clk(clk), .pin_o(pin_o), .pin_oe_b(pin_oe_b), .reset_b(rst_in_b), .fast_pins(fast));
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk
    // Single word transfer; waits on ready in both phases
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        req <= '{htrans: 2'b10, hwrite: w, hsize: 3'b010, haddr: a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        req.htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, far beyond the expected run
    initial begin
        #200000;
        miscompares++;
        results();
    end
    // Main sequence
    initial begin
        {rst_b, hsel, irq, rtc, can, busy} = '0;
        {bidir, reset_delay_pin, ea, nmi_b, rdy, lp} = '1;
        req = '0;
        hwdata = 32'h0000_0000;
        p0 = 16'h1234;
        cfg_exp = 16'h1234;
        fen = 8'h01;
        fhi = 8'h01;
        miscompares = 0;
        checks = 0;
        rows = '{'{0, 6, 1, 0, 16'hA5A5, 5'h05, 16'h1FFF}, '{0, 30, 1, 0, 16'h5A5A, 5'h0F, 16'hFFFF},
            '{0, 6, 0, 0, 16'hC3C3, 5'h0F, 16'hFFFF}, '{1, 0, 1, 4'h4, 16'hFFFF, 5'h01, 16'h1FC0},
            '{1, 0, 1, 4'h8, 16'h0000, 5'h03, 16'h1FC0}, '{0, 6, 1, 0, 16'h9669, 5'h05, 16'h1FFF}};
        wait_clk(4);
        rst_b <= 1'b1;
        wait_clk(3);
        // Reset kinds: flags and sampled configuration
        foreach (rows[i]) begin
            p0 <= rows[i].p;
            reset_delay_pin <= rows[i].d;
            wait_clk(3);
            if (rows[i].c) begin
                bus(1'b1, 12'h00C, {28'h000_0000, rows[i].cmd}, rd);
            end else begin
                ext.hold_reset(rows[i].n);
            end
            wait_clk(16);
            cfg_exp = (cfg_exp & ~rows[i].m) | (rows[i].p & rows[i].m);
            bus(1'b0, 12'h004, 32'h0000_0000, rd);
            `CHK(rd[4:0], rows[i].f)
            bus(1'b0, 12'h008, 32'h0000_0000, rd);
            `CHK(rd[15:0], cfg_exp)
        end
        // Second reset in mid-run, then an unmapped read
        rst_b <= 1'b0;
        wait_clk(4);
        rst_b <= 1'b1;
        wait_clk(3);
        bus(1'b0, 12'h004, 32'h0000_0000, rd);
        `CHK(rd[7:0], 8'h3F)
        `CHK(cfg, p0)
        `CHK(use_lp, 1'b1)
        bus(1'b0, 12'h010, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0000)
        // Idle entry guarded by ready and bus activity
        bus(1'b1, 12'h000, 32'h0000_0008, rd);
        rdy <= 1'b0;
        bus(1'b1, 12'h00C, 32'h0000_0001, rd);
        wait_clk(2);
        `CHK({cpu_stop, refused}, 2'b01)
        rdy <= 1'b1;
        busy <= 1'b1;
        bus(1'b1, 12'h00C, 32'h0000_0001, rd);
        wait_clk(2);
        `CHK({cpu_stop, refused}, 2'b01)
        busy <= 1'b0;
        bus(1'b1, 12'h00C, 32'h0000_0001, rd);
        wait_clk(2);
        `CHK({cpu_stop, per_stop, refused}, 3'b100)
        irq <= 1'b1;
        wait_clk(5);
        `CHK(cpu_stop, 1'b0)
        irq <= 1'b0;
        // Protected power-down: NMI guard, only reset wakes
        bus(1'b1, 12'h000, 32'h0000_0001, rd);
        bus(1'b1, 12'h00C, 32'h0000_0002, rd);
        wait_clk(2);
        `CHK({per_stop, refused}, 2'b01)
        nmi_b <= 1'b0;
        wait_clk(3);
        bus(1'b1, 12'h00C, 32'h0000_0002, rd);
        wait_clk(2);
        `CHK({per_stop, wd_hold}, 2'b11)
        {nmi_b, rtc, can} <= 3'b111;
        ext.pulse(0, 3);
        wait_clk(4);
        `CHK(per_stop, 1'b1)
        {rtc, can} <= 2'b00;
        ext.hold_reset(6);
        wait_clk(8);
        `CHK(per_stop, 1'b0)
        // Interruptible power-down: pin guard, then each wake source
        fhi <= 8'h00;
        bus(1'b1, 12'h000, 32'h0000_0023, rd);
        bus(1'b0, 12'h000, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0023)
        bus(1'b1, 12'h00C, 32'h0000_0002, rd);
        wait_clk(2);
        `CHK({per_stop, refused}, 2'b01)
        fhi <= 8'h01;
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 12'h000, (i == 0) ? 32'h0000_0023 : 32'h0000_0027, rd);
            bus(1'b1, 12'h00C, 32'h0000_0002, rd);
            wait_clk(2);
            `CHK({per_stop, osc_run, use_lp}, (i == 0) ? 3'b101 : 3'b110)
            case (i)
                0: ext.pulse(0, 3);
                1: rtc <= 1'b1;
                default: can <= 1'b1;
            endcase
            wait_clk(5);
            `CHK(per_stop, 1'b0)
            {rtc, can} <= 2'b00;
        end
        results();
    end
endmodule : rfpm_tb_top
`default_nettype wire
